// *** logic/sws_pkg.sv ***
// What this block does
// - While the port runs as RTU slave, a recognised programming master makes the block drop RTU and install the programming slave.
// - The automatic programming slave answers with a turnaround delay of zero milliseconds.
// - The automatic programming slave uses an idle timeout of ten seconds.
// - After the master goes away the port processes no messages until the idle timeout has run out.
// - Expiry of the idle timeout is taken as the sign that the master has been removed.
// - On that sign the RTU slave comes back, unless a new configuration was stored meanwhile, which is then installed.
// - A configuration stored during the session waits and takes effect only once the master is lost.
// - No break is needed to attach, and a break seen by the slave resets the session to wait for a new attach.
// - The programming slave works on point-to-point and on multi-drop links.
// - At most thirty-two permanent datagrams exist, and further establish requests are denied until some are cancelled.
// - Permanent datagrams outlive the session that created them.
// - All permanent datagrams are lost when power is cycled.
// - The ports act only as slaves, RTU or programming, and give no master service.
// - In RTU mode a gap of four character times ends an incoming message, and no answer is sent for it.
package sws_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned IDLE_S = 10;
   localparam int unsigned IDLE_CYC = CLK_HZ * IDLE_S;
   localparam int unsigned IDLE_W = 28;
   localparam int unsigned TURN_MS = 0;
   localparam int unsigned TURN_CYC = TURN_MS * (CLK_HZ / 1000);
   localparam logic [2:0] GAP_CHARS = 3'h4;
   // ==========================================================
   // Attach message
   localparam logic [7:0] ATT_SOF = 8'h1b;
   localparam logic [7:0] ATT_TYPE = 8'h41;
   localparam logic [7:0] ATT_BLANK = 8'h00;
   localparam logic [3:0] ATT_LEN = 4'ha;
   // ==========================================================
   // Register map
   localparam logic [7:0] A_STAT = 8'h00;
   localparam logic [7:0] A_CFG = 8'h04;
   localparam logic [7:0] A_PEND = 8'h08;
   localparam logic [7:0] A_DG = 8'h0c;
   localparam logic [7:0] A_MSTR = 8'h10;
   localparam int ST_MODE = 0;
   localparam int ST_ATT = 2;
   localparam int ST_PEND = 3;
   localparam int ST_MDEN = 4;
   localparam int ST_CNT = 8;
   localparam int DG_OP = 7;
   localparam int DG_DENY = 8;
   localparam int MS_REQ = 0;
   localparam int MS_CLR = 1;
   localparam int CFG_W = 16;
   localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
   localparam logic [1:0] PROTO_PRG = 2'h1;
   localparam int DG_MAX = 32;
   localparam int DG_IW = 5;
   localparam int DG_CW = 6;

   typedef enum logic [1:0] {
      SWS_RTU = 2'b00,
      SWS_PRG = 2'b01,
      SWS_GONE = 2'b11
   } sws_mode_t;

   // Byte-lane merge of a write into a 16-bit register.
   function automatic logic [CFG_W-1:0] sws_merge(input logic [CFG_W-1:0] old, input logic [31:0] wd,
                                                  input logic [3:0] sel);
      logic [CFG_W-1:0] m;
      m = old;
      if (sel[0]) m[7:0] = wd[7:0];
      if (sel[1]) m[15:8] = wd[15:8];
      return m;
   endfunction
endpackage

// *** logic/sws_tmr.sv ***
`timescale 1ns/1ps
module sws_tmr #(parameter int W = 4) (
   // System.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // Control.
   input wire logic restart,
   input wire logic tick,
   input wire logic [W-1:0] load,
   // Status.
   output logic expired,
   output logic running
);
   import sws_pkg::*;

   typedef struct packed {
      logic [W-1:0] cnt;
      logic run;
      logic exp;
   } sws_tmr_t;

   sws_tmr_t st_r, st_nxt;

   // ==========================================================
   // Countdown
   always_comb begin
      st_nxt = st_r;
      st_nxt.exp = 1'b0;
      if (restart) begin
         st_nxt.cnt = load;
         st_nxt.run = |load;
      end else if (st_r.run && tick) begin
         if (st_r.cnt == W'(1)) begin
            st_nxt.run = 1'b0;
            st_nxt.exp = 1'b1;
         end
         st_nxt.cnt = st_r.cnt - W'(1);
      end
      if (!ce) st_nxt = st_r;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign expired = st_r.exp;
   assign running = st_r.run;

   property p_exp;
      @(posedge core_clk) disable iff (!nrst)
      ce && st_r.run && tick && !restart && st_r.cnt == W'(1) |=> expired ##1 !expired;
   endproperty
   a_exp: assert property (p_exp) else $error("timer missed its expiry");
endmodule

// *** logic/sws_dgpool.sv ***
`timescale 1ns/1ps
module sws_dgpool (
   // System.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // Requests.
   input wire logic est,
   input wire logic cancel,
   input wire logic [sws_pkg::DG_IW-1:0] idx,
   // Results.
   output logic [sws_pkg::DG_IW-1:0] res_idx,
   output logic denied,
   output logic [sws_pkg::DG_CW-1:0] count
);
   import sws_pkg::*;

   typedef struct packed {
      logic [DG_MAX-1:0] used;
      logic [DG_IW-1:0] res;
      logic den;
      logic [DG_CW-1:0] cnt;
   } sws_pool_t;

   sws_pool_t st_r, st_nxt;

   function automatic logic [DG_IW-1:0] first_free(input logic [DG_MAX-1:0] u);
      logic [DG_IW-1:0] f;
      f = '0;
      for (int i = DG_MAX - 1; i >= 0; i--) begin
         if (!u[i]) f = DG_IW'(i);
      end
      return f;
   endfunction

   function automatic logic [DG_CW-1:0] pop(input logic [DG_MAX-1:0] u);
      logic [DG_CW-1:0] c;
      c = '0;
      for (int i = 0; i < DG_MAX; i++) begin
         c = c + DG_CW'(u[i]);
      end
      return c;
   endfunction

   // ==========================================================
   // Slot table
   // Slots are freed only by a cancel or by reset, so they outlive any session.
   always_comb begin
      st_nxt = st_r;
      if (est) begin
         if (&st_r.used) begin
            st_nxt.den = 1'b1;
         end else begin
            st_nxt.den = 1'b0;
            st_nxt.res = first_free(st_r.used);
            st_nxt.used[first_free(st_r.used)] = 1'b1;
         end
      end else if (cancel) begin
         st_nxt.used[idx] = 1'b0;
      end
      st_nxt.cnt = pop(st_nxt.used);
      if (!ce) st_nxt = st_r;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign res_idx = st_r.res;
   assign denied = st_r.den;
   assign count = st_r.cnt;

   property p_full;
      @(posedge core_clk) disable iff (!nrst)
      ce && est && (&st_r.used) |=> denied && count == DG_CW'(DG_MAX);
   endproperty
   a_full: assert property (p_full) else $error("establish not denied when full");

   property p_keep;
      @(posedge core_clk) disable iff (!nrst)
      !(ce && cancel) |=> ($past(st_r.used) & ~st_r.used) == '0;
   endproperty
   a_keep: assert property (p_keep) else $error("datagram lost without cancel");
endmodule

// *** logic/sws_switch.sv ***
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module sws_switch #(parameter int unsigned IDLE_CYCLES = sws_pkg::IDLE_CYC) (
   // System.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic ack_o,
   output logic [31:0] dat_o,
   // Character engine of the port.
   input wire logic rx_vld,
   input wire logic [7:0] rx_byte,
   input wire logic rx_brk,
   input wire logic char_tick,
   // Protocol handlers.
   input wire logic resp_req,
   output logic resp_go,
   output logic rtu_rx_en,
   output logic prog_rx_en,
   output logic rtu_msg_end,
   output logic rtu_msg_drop,
   output logic [1:0] proto_mode,
   output logic [sws_pkg::CFG_W-1:0] line_cfg
);
   import sws_pkg::*;

   typedef struct packed {
      sws_mode_t mode;
      logic att;
      logic [3:0] att_cnt;
      logic [CFG_W-1:0] cfg;
      logic [CFG_W-1:0] pend;
      logic pend_v;
      logic mden;
      logic ack;
      logic gap_end;
      logic drop;
      logic [31:0] dat;
   } sws_st_t;

   sws_st_t st_r, st_nxt;

   logic gap_exp;
   logic idle_exp;
   logic wr;
   logic dg_est;
   logic dg_cancel;
   logic [DG_IW-1:0] dg_res;
   logic dg_den;
   logic [DG_CW-1:0] dg_cnt;
   logic [7:0] att_exp;
   logic hunt;
   logic [31:0] rd;

   // ==========================================================
   // Bus decode
   // A write lands on the edge at which the master sees ack.
   assign wr = cyc_i && stb_i && we_i && st_r.ack;
   assign dg_est = ce && wr && adr_i == A_DG && dat_i[DG_OP];
   assign dg_cancel = ce && wr && adr_i == A_DG && !dat_i[DG_OP];

   always_comb begin
      rd = '0;
      case (adr_i)
         A_STAT: begin
            rd[ST_MODE +: 2] = st_r.mode;
            rd[ST_ATT] = st_r.att;
            rd[ST_PEND] = st_r.pend_v;
            rd[ST_MDEN] = st_r.mden;
            rd[ST_CNT +: DG_CW] = dg_cnt;
         end
         A_CFG: rd[CFG_W-1:0] = st_r.cfg;
         A_PEND: rd[CFG_W-1:0] = st_r.pend;
         A_DG: begin
            rd[DG_IW-1:0] = dg_res;
            rd[DG_DENY] = dg_den;
         end
         default: rd = '0;
      endcase
   end

   // ==========================================================
   // Attach recognition
   // The matcher listens only where a new attach may come: under RTU,
   // or in a programming session with no accepted attach (after a break, or one installed from a pending configuration).
   assign hunt = st_r.mode == SWS_RTU || (st_r.mode == SWS_PRG && !st_r.att);

   always_comb begin
      case (st_r.att_cnt)
         4'h0: att_exp = ATT_SOF;
         4'h1: att_exp = ATT_TYPE;
         default: att_exp = ATT_BLANK;
      endcase
   end

   // ==========================================================
   // Protocol state
   always_comb begin
      st_nxt = st_r;
      st_nxt.gap_end = 1'b0;
      st_nxt.drop = 1'b0;
      st_nxt.ack = cyc_i && stb_i && !st_r.ack;
      if (cyc_i && stb_i && !st_r.ack && !we_i) st_nxt.dat = rd;

      case (st_r.mode)
         SWS_RTU: begin
            if (gap_exp) begin
               st_nxt.gap_end = 1'b1;
               st_nxt.att_cnt = '0;
            end
         end
         SWS_PRG: begin
            // Expiry is tested first: a break in the same cycle must not swallow
            // the only sign that the master has gone, or the session would hang.
            if (idle_exp) begin
               st_nxt.mode = SWS_GONE;
               st_nxt.att = 1'b0;
               st_nxt.att_cnt = '0;
            end else if (rx_brk) begin
               st_nxt.att = 1'b0;
               st_nxt.att_cnt = '0;
            end
         end
         SWS_GONE: begin
            // A pending configuration replaces RTU when the master is lost.
            if (st_r.pend_v) begin
               st_nxt.cfg = st_r.pend;
               st_nxt.pend_v = 1'b0;
               st_nxt.mode = (st_r.pend[1:0] == PROTO_PRG) ? SWS_PRG : SWS_RTU;
            end else begin
               st_nxt.mode = SWS_RTU;
            end
         end
         default: st_nxt.mode = SWS_RTU;
      endcase

      // Bytes arrive at the settings already in force, so a master on other
      // settings never produces a clean attach here.
      if (rx_vld && hunt && !(st_r.mode == SWS_PRG && rx_brk)) begin
         if (rx_byte == att_exp) begin
            if (st_r.att_cnt == ATT_LEN - 4'h1) begin
               st_nxt.mode = SWS_PRG;
               st_nxt.att = 1'b1;
               st_nxt.att_cnt = '0;
               st_nxt.drop = st_r.mode == SWS_RTU;
            end else begin
               st_nxt.att_cnt = st_r.att_cnt + 4'h1;
            end
         end else begin
            st_nxt.att_cnt = (rx_byte == ATT_SOF) ? 4'h1 : 4'h0;
         end
      end

      if (wr && adr_i == A_CFG) begin
         if (st_r.mode == SWS_RTU) begin
            st_nxt.cfg = sws_merge(st_r.cfg, dat_i, sel_i);
         end else begin
            st_nxt.pend = sws_merge(st_r.pend, dat_i, sel_i);
            st_nxt.pend_v = 1'b1;
         end
      end

      // No master service exists; a request only raises a refusal flag,
      // and a new request wins over a clear in the same write.
      if (wr && adr_i == A_MSTR) begin
         if (dat_i[MS_REQ]) st_nxt.mden = 1'b1;
         else if (dat_i[MS_CLR]) st_nxt.mden = 1'b0;
      end

      if (!ce) st_nxt = st_r;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.mode <= SWS_RTU;
         st_r.cfg <= CFG_RST;
         st_r.pend <= CFG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Timers and datagram pool
   sws_tmr #(.W(3)) u_gap (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .restart(rx_vld && st_r.mode == SWS_RTU),
      .tick(char_tick),
      .load(GAP_CHARS),
      .expired(gap_exp),
      .running()
   );

   // Any byte in the session, or entry into it, restarts the idle count.
   sws_tmr #(.W(IDLE_W)) u_idle (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .restart((st_r.mode == SWS_PRG && rx_vld) || (st_r.mode != SWS_PRG && st_nxt.mode == SWS_PRG)),
      .tick(1'b1),
      .load(IDLE_W'(IDLE_CYCLES)),
      .expired(idle_exp),
      .running()
   );

   sws_dgpool u_pool (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .est(dg_est),
      .cancel(dg_cancel),
      .idx(dat_i[DG_IW-1:0]),
      .res_idx(dg_res),
      .denied(dg_den),
      .count(dg_cnt)
   );

   // ==========================================================
   // Outputs
   assign ack_o = st_r.ack;
   assign dat_o = st_r.dat;
   assign proto_mode = st_r.mode;
   assign line_cfg = st_r.cfg;
   assign rtu_rx_en = st_r.mode == SWS_RTU;
   // Forwarding needs an accepted attach but no station match, which serves
   // point-to-point and multi-drop links alike.
   assign prog_rx_en = st_r.mode == SWS_PRG && st_r.att;
   assign rtu_msg_end = st_r.gap_end;
   assign rtu_msg_drop = st_r.drop;
   // Zero turnaround: the grant follows the request in the same cycle.
   assign resp_go = resp_req && prog_rx_en && TURN_CYC == 0;

   // ==========================================================
   // Checks
   property p_att;
      @(posedge core_clk) disable iff (!nrst)
      ce && rx_vld && st_r.mode == SWS_RTU && st_r.att_cnt == ATT_LEN - 4'h1 && rx_byte == ATT_BLANK
      |=> proto_mode == SWS_PRG && prog_rx_en && rtu_msg_drop;
   endproperty
   a_att: assert property (p_att) else $error("attach did not install the programming slave");

   property p_turn;
      @(posedge core_clk) disable iff (!nrst)
      resp_req && prog_rx_en |-> resp_go;
   endproperty
   a_turn: assert property (p_turn) else $error("response grant delayed");

   property p_hold;
      @(posedge core_clk) disable iff (!nrst)
      ce && st_r.mode == SWS_PRG && !idle_exp |=> st_r.mode == SWS_PRG;
   endproperty
   a_hold: assert property (p_hold) else $error("session left before idle expiry");

   property p_back;
      @(posedge core_clk) disable iff (!nrst)
      ce && st_r.mode == SWS_GONE && !st_r.pend_v |=> proto_mode == SWS_RTU && line_cfg == $past(line_cfg);
   endproperty
   a_back: assert property (p_back) else $error("RTU not reinstalled");

   property p_pend;
      @(posedge core_clk) disable iff (!nrst)
      st_r.mode == SWS_PRG |=> $stable(line_cfg);
   endproperty
   a_pend: assert property (p_pend) else $error("configuration applied during session");

   property p_brk;
      @(posedge core_clk) disable iff (!nrst)
      ce && rx_brk && st_r.mode == SWS_PRG && !idle_exp |=> !prog_rx_en && proto_mode == SWS_PRG;
   endproperty
   a_brk: assert property (p_brk) else $error("break did not reset the session");

   property p_mden;
      @(posedge core_clk) disable iff (!nrst)
      ce && wr && adr_i == A_MSTR && dat_i[MS_REQ] |=> st_r.mden;
   endproperty
   a_mden: assert property (p_mden) else $error("master request not refused");

   property p_gap;
      @(posedge core_clk) disable iff (!nrst)
      ce && gap_exp && st_r.mode == SWS_RTU |=> rtu_msg_end ##1 !rtu_msg_end;
   endproperty
   a_gap: assert property (p_gap) else $error("character gap did not end the message");

   property p_lost;
      @(posedge core_clk) disable iff (!nrst)
      ce && st_r.mode == SWS_PRG && idle_exp && !rx_vld |=> proto_mode == SWS_GONE;
   endproperty
   a_lost: assert property (p_lost) else $error("idle expiry did not end the session");

   property p_apply;
      @(posedge core_clk) disable iff (!nrst)
      ce && st_r.mode == SWS_GONE && st_r.pend_v |=> line_cfg == $past(st_r.pend);
   endproperty
   a_apply: assert property (p_apply) else $error("pending configuration not installed");

   property p_quiet;
      @(posedge core_clk) disable iff (!nrst)
      ce && st_r.mode == SWS_PRG |=> !rtu_rx_en && !rtu_msg_end;
   endproperty
   a_quiet: assert property (p_quiet) else $error("RTU handling active during session");
endmodule

// *** sim/sws_master_mdl.sv ***
`timescale 1ns/1ps
// ==========================================================
// Programming master as seen through the port's character engine
module sws_master_mdl (
   // System.
   input wire logic core_clk,
   input wire logic nrst,
   // Command: 0 attach, 1 corrupt attach, 2 lone byte, 3 break.
   input wire logic start,
   input wire logic [1:0] kind,
   input wire logic slow,
   // Receive side of the port.
   output logic rx_vld,
   output logic [7:0] rx_byte,
   output logic rx_brk,
   output logic busy
);
   import sws_pkg::*;
   logic [1:0] k;
   logic [7:0] b;
   int n;
   int gap;
   // Bytes reach the block through the port's own receiver, so they share its line settings.
   always_comb begin
      if (k == 2'h2) b = 8'h33;
      else if (n == 0) b = ATT_SOF;
      else if (n == 1) b = ATT_TYPE;
      else if (k == 2'h1 && n == 2) b = 8'h55;
      else b = ATT_BLANK;
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rx_vld <= 1'b0;
         rx_brk <= 1'b0;
         rx_byte <= 8'h00;
         busy <= 1'b0;
         n <= 0;
         gap <= 0;
         k <= 2'h0;
      end else begin
         rx_vld <= 1'b0;
         rx_brk <= 1'b0;
         // Outside a strobe the data keeps moving, so a stale byte can never pass for a fresh one.
         rx_byte <= ~rx_byte;
         if (!busy && start) begin
            busy <= 1'b1;
            k <= kind;
            n <= 0;
            gap <= 0;
         end else if (busy && gap != 0) begin
            gap <= gap - 1;
         end else if (busy && k == 2'h3) begin
            rx_brk <= 1'b1;
            busy <= 1'b0;
         end else if (busy) begin
            // The attach goes out with no break in front of it.
            rx_vld <= 1'b1;
            rx_byte <= b;
            gap <= slow ? 3 : 0;
            n <= n + 1;
            if (k == 2'h2 || n == int'(ATT_LEN) - 1) busy <= 1'b0;
         end
      end
   end
endmodule

// *** sim/tb_sws_switch.sv ***
`timescale 1ns/1ps
module tb_sws_switch;
   import sws_pkg::*;
   // A short idle count keeps the loss scenarios brief.
   localparam int unsigned IDLE = 200;
   typedef struct {logic we; logic [7:0] a; logic [3:0] s; logic [31:0] d;} sws_row_t;
   logic core_clk, ack_o, resp_go, rtu_rx_en, prog_rx_en, rtu_msg_end, rtu_msg_drop, rx_vld, rx_brk, busy;
   logic nrst = 1'b0, ce = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, char_tick = 1'b0, resp_req = 1'b0;
   logic start = 1'b0, slow = 1'b0;
   logic [1:0] kind = 2'h0;
   logic [7:0] adr_i = 8'h00;
   logic [7:0] rx_byte;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [1:0] proto_mode;
   logic [CFG_W-1:0] line_cfg;
   int error_cnt = 0, n_checks = 0, n_end = 0, n_drop = 0, n_gone = 0, e0, i;
   sws_row_t rows[17] = '{'{1'b1, A_CFG, 4'hf, 32'h1234}, '{1'b0, A_CFG, 4'hf, 32'h1234},
      '{1'b1, A_CFG, 4'h1, 32'h00ff}, '{1'b0, A_CFG, 4'hf, 32'h12ff}, '{1'b1, A_CFG, 4'h2, 32'h0000},
      '{1'b0, A_CFG, 4'hf, 32'h00ff}, '{1'b1, A_CFG, 4'hf, 32'h0000}, '{1'b1, A_STAT, 4'hf, 32'hffff},
      '{1'b0, A_STAT, 4'hf, 32'h0}, '{1'b0, A_PEND, 4'hf, 32'h0}, '{1'b1, 8'h20, 4'hf, 32'h5a5a},
      '{1'b0, 8'h20, 4'hf, 32'h0}, '{1'b1, A_MSTR, 4'hf, 32'h3}, '{1'b0, A_STAT, 4'hf, 32'h10},
      '{1'b1, A_MSTR, 4'hf, 32'h2}, '{1'b0, A_STAT, 4'hf, 32'h0}, '{1'b0, A_MSTR, 4'hf, 32'h0}};
   sws_switch #(.IDLE_CYCLES(IDLE)) dut_u (.core_clk(core_clk), .nrst(nrst), .ce(ce), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
      .rx_vld(rx_vld), .rx_byte(rx_byte), .rx_brk(rx_brk), .char_tick(char_tick), .resp_req(resp_req),
      .resp_go(resp_go), .rtu_rx_en(rtu_rx_en), .prog_rx_en(prog_rx_en), .rtu_msg_end(rtu_msg_end),
      .rtu_msg_drop(rtu_msg_drop), .proto_mode(proto_mode), .line_cfg(line_cfg));
   sws_master_mdl pm_u (.core_clk(core_clk), .nrst(nrst), .start(start), .kind(kind), .slow(slow),
      .rx_vld(rx_vld), .rx_byte(rx_byte), .rx_brk(rx_brk), .busy(busy));
   // ==========================================================
   // Clock, pulse counters and watchdog
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Pulses are counted so that a scenario never has to catch them in one exact cycle.
   always @(posedge core_clk) begin
      if (rtu_msg_end === 1'b1) n_end++;
      if (rtu_msg_drop === 1'b1) n_drop++;
      if (proto_mode === SWS_GONE) n_gone++;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fail("watchdog expired");
      close_out();
   end
   // ==========================================================
   // Tasks
   task automatic fail(input string m);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic chk_v(input logic [31:0] g, input logic [31:0] e, input string m);
      n_checks++;
      if (g !== e) fail($sformatf("%s got %h expected %h", m, g, e));
   endtask
   task automatic chk_b(input logic g, input logic e, input string m);
      n_checks++;
      if (g !== e) fail($sformatf("%s got %b expected %b", m, g, e));
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge core_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do begin
         @(posedge core_clk);
         t++;
      end while (ack_o !== 1'b1 && t < 20);
      if (ack_o !== 1'b1) fail("no bus answer");
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic send(input logic [1:0] k, input logic s);
      int t;
      t = 0;
      @(posedge core_clk);
      start <= 1'b1;
      kind <= k;
      slow <= s;
      @(posedge core_clk);
      start <= 1'b0;
      do begin
         @(posedge core_clk);
         t++;
      end while (busy !== 1'b0 && t < 100);
      repeat (2) @(posedge core_clk);
   endtask
   task automatic tick_n(input int n);
      repeat (n) begin
         @(posedge core_clk);
         char_tick <= 1'b1;
         @(posedge core_clk);
         char_tick <= 1'b0;
      end
   endtask
   task automatic wait_gone(input int lim);
      int t;
      t = 0;
      while (n_gone == e0 && t < lim) begin
         @(posedge core_clk);
         t++;
      end
      chk_v(n_gone - e0, 1, "master loss seen");
      repeat (3) @(posedge core_clk);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      for (i = 0; i < 17; i++) begin
         wb(rows[i].we, rows[i].a, rows[i].s, rows[i].d);
         if (!rows[i].we) chk_v(rd, rows[i].d, "register row");
      end
      $display("register rows done");
      e0 = n_end;
      send(2'h2, 1'b0);
      tick_n(3);
      repeat (3) @(posedge core_clk);
      chk_v(n_end - e0, 0, "gap of three");
      tick_n(1);
      repeat (3) @(posedge core_clk);
      chk_v(n_end - e0, 1, "gap of four");
      $display("character gap done");
      for (i = 0; i < 32; i++) wb(1'b1, A_DG, 4'hf, 32'h80);
      wb(1'b0, A_DG, 4'hf, 32'h0);
      chk_b(rd[DG_DENY], 1'b0, "last free slot");
      wb(1'b1, A_DG, 4'hf, 32'h80);
      wb(1'b0, A_DG, 4'hf, 32'h0);
      chk_b(rd[DG_DENY], 1'b1, "pool full");
      wb(1'b0, A_STAT, 4'hf, 32'h0);
      chk_v(32'(rd[ST_CNT +: DG_CW]), 32, "pool count");
      wb(1'b1, A_DG, 4'hf, 32'h05);
      wb(1'b1, A_DG, 4'hf, 32'h80);
      wb(1'b0, A_DG, 4'hf, 32'h0);
      chk_v(32'(rd[8:0]), 32'h5, "freed slot reused");
      $display("datagram pool done");
      e0 = n_drop;
      send(2'h1, 1'b0);
      chk_v(32'(proto_mode), 32'(SWS_RTU), "corrupt attach");
      @(posedge core_clk) resp_req <= 1'b1;
      @(negedge core_clk) chk_b(resp_go, 1'b0, "answer under RTU");
      send(2'h0, 1'b1);
      chk_v(32'(proto_mode), 32'(SWS_PRG), "attach mode");
      chk_b(rtu_rx_en, 1'b0, "RTU removed");
      chk_b(prog_rx_en, 1'b1, "slave attached");
      chk_v(n_drop - e0, 1, "drop pulse");
      @(negedge core_clk) chk_b(resp_go, 1'b1, "zero turnaround");
      wb(1'b1, A_CFG, 4'h3, 32'h0021);
      chk_v(32'(line_cfg), 32'h0, "config held back");
      wb(1'b0, A_PEND, 4'hf, 32'h0);
      chk_v(rd, 32'h21, "pending config");
      wb(1'b0, A_STAT, 4'hf, 32'h0);
      chk_v(32'(rd[3:0]), 32'hd, "status in session");
      $display("attach done");
      send(2'h3, 1'b0);
      chk_b(prog_rx_en, 1'b0, "break detaches");
      chk_v(32'(proto_mode), 32'(SWS_PRG), "break keeps mode");
      @(negedge core_clk) chk_b(resp_go, 1'b0, "no answer after break");
      send(2'h0, 1'b0);
      chk_b(prog_rx_en, 1'b1, "new attach");
      $display("break done");
      // Freezing ce for 40 cycles must push the loss out by as much.
      @(posedge core_clk) ce <= 1'b0;
      repeat (40) @(posedge core_clk);
      ce <= 1'b1;
      e0 = n_gone;
      repeat (IDLE - 30) @(posedge core_clk);
      chk_v(32'(proto_mode), 32'(SWS_PRG), "still waiting");
      chk_v(n_gone - e0, 0, "no early loss");
      wait_gone(60);
      chk_v(32'(line_cfg), 32'h0021, "pending applied");
      chk_v(32'(proto_mode), 32'(SWS_PRG), "new protocol");
      wb(1'b0, A_STAT, 4'hf, 32'h0);
      chk_v(32'(rd[ST_CNT +: DG_CW]), 32, "datagrams kept");
      $display("loss with pending done");
      @(posedge core_clk) nrst <= 1'b0;
      @(negedge core_clk) chk_v(32'(proto_mode), 32'(SWS_RTU), "reset mode");
      chk_v(32'(line_cfg), 32'h0, "reset config");
      chk_b(rtu_rx_en, 1'b1, "reset RTU enable");
      chk_b(prog_rx_en, 1'b0, "reset attach");
      chk_b(ack_o, 1'b0, "reset ack");
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      wb(1'b0, A_STAT, 4'hf, 32'h0);
      chk_v(rd, 32'h0, "pool empty after power cycle");
      e0 = n_gone;
      send(2'h0, 1'b0);
      chk_v(32'(proto_mode), 32'(SWS_PRG), "second attach");
      wait_gone(IDLE + 40);
      chk_v(32'(proto_mode), 32'(SWS_RTU), "RTU back");
      chk_b(rtu_rx_en, 1'b1, "RTU enabled");
      $display("reset and return done");
      close_out();
   end
endmodule
